/* ctm_timing.sv */
`timescale 1ns/10ps
// Behaviour
// - register add, logic, move: one byte, one clock
// - indirect ram accumulator ops: one byte, two clocks
// - direct operand accumulator ops: two bytes, two clocks
// - immediate accumulator ops: two bytes, two clocks
// - logic immediate into direct: three bytes, three clocks
// - logic accumulator into direct: two bytes, two clocks
// - direct to direct move: three bytes, three clocks
// - data pointer immediate load: three bytes, three clocks
// - code read via data pointer: one byte, 4-7
// - code read via program counter: one byte, three
// - external data transfers: one byte, three clocks
// - push and pop: two bytes, two clocks
// - nibble exchange indirect: one byte, two clocks
// - exchange direct 2/2, exchange register 1/1
// - rotates, swap, clear one clock; complement two
// - direct to indirect 2/2, accumulator 1/2
// - indirect to direct: two bytes, two clocks
// - inc/dec/da one clock; multiply four, divide eight
// - durations counted in plain system clocks
// - register operand picks one of eight in bank
// - indirect address from pointer register zero or one
// - direct below 0x80 ram, above special registers
module ctm_timing
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // instruction offer from fetch
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_arg,
  // core context
  input wire logic [ctm_pkg::CTM_BANK_W-1:0] bank_sel,
  input wire logic [7:0] acc_in,
  input wire logic [7:0] opnd_in,
  input wire logic cy_in,
  input wire logic ac_in,
  input wire logic ov_in,
  // code memory answer for the stretched code read
  input wire logic code_rdy,
  // sequencing
  output logic op_ready,
  output logic busy,
  output logic ins_done,
  output logic [1:0] ins_len,
  output logic [3:0] ins_cyc,
  output logic [3:0] cyc_cnt,
  output logic ins_known,
  // operand addressing
  output logic [ctm_pkg::CTM_RADR_W-1:0] reg_addr,
  output logic [ctm_pkg::CTM_RADR_W-1:0] ptr_addr,
  output logic direct_sfr,
  // accumulator result and flags
  output logic [7:0] alu_res,
  output logic alu_wr,
  output logic alu_cy,
  output logic alu_ac,
  output logic alu_ov
);
  import ctm_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // decode
  ////////////////////////////////////////////////////////////////////

  logic [1:0] dec_len; // bytes of the offered opcode
  logic [3:0] dec_cyc; // clocks, or least clocks when stretched
  logic dec_var; // duration depends on code memory
  logic dec_known; // opcode belongs to this table

  // lookup of length and duration from the opcode alone
  ctm_decode u_decode (
    .op_code(op_code),
    .dec_len(dec_len),
    .dec_cyc(dec_cyc),
    .dec_var(dec_var),
    .dec_known(dec_known)
  );

  ////////////////////////////////////////////////////////////////////
  // sequencer
  ////////////////////////////////////////////////////////////////////

  ctm_state_e state_reg; // idle or executing
  ctm_state_e state_next;
  logic [3:0] cnt_reg; // clock of current instruction, from one
  logic [3:0] cnt_next;
  logic [3:0] cyc_reg; // duration of current instruction
  logic var_reg; // current instruction is stretchable
  logic ready_reg; // this clock is the last of the instruction
  logic ready_next;
  logic take; // new instruction accepted this clock
  logic [3:0] cnt_inc; // next clock number

  assign take = op_valid & ready_reg;
  assign cnt_inc = cnt_reg + CTM_CYC_1;

  // next state: a new opcode is taken in the very clock that ends
  // the previous one, so back to back code runs with no gap
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    ready_next = ready_reg;
    if (take) begin
      state_next = CTM_EXEC;
      cnt_next = CTM_CYC_1;
      ready_next = (dec_cyc == CTM_CYC_1) && !dec_var;
    end else begin
      unique case (state_reg)
        CTM_IDLE: begin
          ready_next = 1'b1;
        end
        CTM_EXEC: begin
          if (ready_reg) begin
            // ended with nothing offered
            state_next = CTM_IDLE;
            ready_next = 1'b1;
          end else begin
            cnt_next = cnt_inc;
            if (var_reg) begin
              // stretch until code memory answers, capped
              ready_next = (cnt_inc == CTM_VAR_MAX) ||
                           ((cnt_inc >= CTM_VAR_MIN) && code_rdy);
            end else begin
              ready_next = (cnt_inc == cyc_reg);
            end
          end
        end
      endcase
    end
  end

  // sequencer state
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= CTM_IDLE;
      cnt_reg <= 4'h0;
      ready_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      ready_reg <= ready_next;
    end
  end

  // latched description of the running instruction
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cyc_reg <= 4'h0;
      var_reg <= 1'b0;
      ins_len <= 2'h0;
      ins_known <= 1'b0;
    end else if (take) begin
      cyc_reg <= dec_cyc;
      var_reg <= dec_var;
      ins_len <= dec_len;
      ins_known <= dec_known;
    end
  end

  // status outputs; done marks the clock after the last one
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      op_ready <= 1'b0;
      busy <= 1'b0;
      ins_done <= 1'b0;
      ins_cyc <= 4'h0;
      cyc_cnt <= 4'h0;
    end else begin
      op_ready <= ready_next;
      busy <= (state_next == CTM_EXEC);
      ins_done <= (state_reg == CTM_EXEC) && ready_reg;
      cyc_cnt <= cnt_next;
      // stretched reads report the clocks actually spent
      if (take) begin
        ins_cyc <= dec_cyc;
      end else if (state_reg == CTM_EXEC && var_reg && !ready_reg) begin
        ins_cyc <= cnt_inc;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // operand addressing
  ////////////////////////////////////////////////////////////////////

  // register, pointer and direct space selection for the new opcode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_addr <= '0;
      ptr_addr <= '0;
      direct_sfr <= 1'b0;
    end else if (take) begin
      reg_addr <= {bank_sel, op_code[2:0]};
      ptr_addr <= {bank_sel, 2'h0, op_code[0]};
      direct_sfr <= op_arg[CTM_SFR_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // accumulator unit
  ////////////////////////////////////////////////////////////////////

  logic [7:0] res; // result byte
  logic wr; // result goes to its destination
  logic cy; // carry out
  logic ac; // auxiliary carry out
  logic ov; // overflow out
  logic [7:0] bx; // second operand, inverted to subtract
  logic ci; // carry into the adder
  logic sub; // subtract with borrow
  logic [4:0] lo_sum; // low nibble sum for auxiliary carry
  logic [7:0] lo7_sum; // seven bit sum for overflow
  logic [8:0] full; // full sum with carry out
  logic [8:0] da1; // decimal adjust, low step
  logic [8:0] da2; // decimal adjust, high step
  logic is_arith; // add, add with carry, subtract forms
  logic is_form; // low nibble names an operand form

  assign is_form = (op_code[3:0] >= 4'h4);
  assign sub = (op_code[7:4] == 4'h9);
  assign bx = sub ? ~opnd_in : opnd_in;
  assign ci = (op_code[7:4] == 4'h3) ? cy_in : (sub ? ~cy_in : 1'b0);
  assign lo_sum = {1'b0, acc_in[3:0]} + {1'b0, bx[3:0]} + {4'h0, ci};
  assign lo7_sum = {1'b0, acc_in[6:0]} + {1'b0, bx[6:0]} + {7'h0, ci};
  assign full = {1'b0, acc_in} + {1'b0, bx} + {8'h0, ci};
  assign is_arith = is_form && (op_code[7:4] == 4'h2 ||
                    op_code[7:4] == 4'h3 || sub);

  // decimal adjust in two nibble steps; carry is never cleared
  always_comb begin
    da1 = {1'b0, acc_in};
    if (acc_in[3:0] > CTM_BCD_MAX || ac_in) begin
      da1 = {1'b0, acc_in} + {5'h0, CTM_BCD_ADJ};
    end
    da2 = da1;
    if (da1[7:4] > CTM_BCD_MAX || da1[8] || cy_in) begin
      da2 = da1 + {1'b0, CTM_BCD_ADJ, 4'h0};
    end
  end

  // results follow the standard semantics; only timing is new
  always_comb begin
    res = acc_in;
    wr = 1'b0;
    cy = cy_in;
    ac = ac_in;
    ov = ov_in;
    if (is_arith) begin
      // borrow is the inverted carry when subtracting
      res = full[7:0];
      wr = 1'b1;
      cy = full[8] ^ sub;
      ac = lo_sum[4] ^ sub;
      ov = full[8] ^ lo7_sum[7];
    end else if ((is_form || op_code[3:1] == 3'h1) &&
                 (op_code[7:4] == 4'h4 || op_code[7:4] == 4'h5 ||
                  op_code[7:4] == 4'h6)) begin
      // logic forms, also into a direct byte; flags untouched
      wr = 1'b1;
      unique case (op_code[7:4])
        4'h4: res = acc_in | opnd_in;
        4'h5: res = acc_in & opnd_in;
        default: res = acc_in ^ opnd_in;
      endcase
    end else if (op_code[7:4] == 4'he && op_code[3:0] >= 4'h5) begin
      res = opnd_in; // load accumulator
      wr = 1'b1;
    end else begin
      case (op_code)
        8'h74: begin
          res = opnd_in; // load immediate
          wr = 1'b1;
        end
        8'h04: begin
          res = acc_in + 8'h01;
          wr = 1'b1;
        end
        8'h14: begin
          res = acc_in - 8'h01;
          wr = 1'b1;
        end
        8'he4: begin
          res = 8'h00;
          wr = 1'b1;
        end
        8'hf4: begin
          res = ~acc_in;
          wr = 1'b1;
        end
        8'h23: begin
          res = {acc_in[6:0], acc_in[7]};
          wr = 1'b1;
        end
        8'h33: begin
          res = {acc_in[6:0], cy_in};
          cy = acc_in[7];
          wr = 1'b1;
        end
        8'h03: begin
          res = {acc_in[0], acc_in[7:1]};
          wr = 1'b1;
        end
        8'h13: begin
          res = {cy_in, acc_in[7:1]};
          cy = acc_in[0];
          wr = 1'b1;
        end
        8'hc4: begin
          res = {acc_in[3:0], acc_in[7:4]};
          wr = 1'b1;
        end
        8'hd4: begin
          res = da2[7:0];
          cy = cy_in | da2[8] | da1[8];
          wr = 1'b1;
        end
        default: wr = 1'b0;
      endcase
    end
  end

  // result registers load with the instruction that makes them
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      alu_res <= 8'h00;
      alu_wr <= 1'b0;
      alu_cy <= 1'b0;
      alu_ac <= 1'b0;
      alu_ov <= 1'b0;
    end else if (take) begin
      alu_res <= res;
      alu_wr <= wr;
      alu_cy <= cy;
      alu_ac <= ac;
      alu_ov <= ov;
    end else begin
      alu_wr <= 1'b0;
    end
  end
endmodule

/* ctm_pkg.sv */
// shared constants for the instruction timing block
package ctm_pkg;
  // instruction lengths in program bytes
  localparam logic [1:0] CTM_LEN_1 = 2'h1;
  localparam logic [1:0] CTM_LEN_2 = 2'h2;
  localparam logic [1:0] CTM_LEN_3 = 2'h3;
  // execution times in system clocks
  localparam logic [3:0] CTM_CYC_1 = 4'h1;
  localparam logic [3:0] CTM_CYC_2 = 4'h2;
  localparam logic [3:0] CTM_CYC_3 = 4'h3;
  localparam logic [3:0] CTM_CYC_4 = 4'h4;
  localparam logic [3:0] CTM_CYC_8 = 4'h8;
  // code read relative to the data pointer stretches over this span
  localparam logic [3:0] CTM_VAR_MIN = 4'h4;
  localparam logic [3:0] CTM_VAR_MAX = 4'h7;
  // decimal adjust thresholds
  localparam logic [3:0] CTM_BCD_MAX = 4'h9;
  localparam logic [3:0] CTM_BCD_ADJ = 4'h6;
  // direct address space split: top bit selects special registers
  localparam int CTM_SFR_BIT = 7;
  // register bank: bank number above a three bit register index
  localparam int CTM_BANK_W = 2;
  localparam int CTM_RADR_W = 5;
  // sequencer states
  typedef enum logic [0:0] {
    CTM_IDLE = 1'b0,
    CTM_EXEC = 1'b1
  } ctm_state_e;
endpackage

/* ctm_decode.sv */
`timescale 1ns/10ps
// opcode to length and duration lookup
module ctm_decode
  import ctm_pkg::*;
(
  // opcode in
  input wire logic [7:0] op_code,
  // lookup results
  output logic [1:0] dec_len,
  output logic [3:0] dec_cyc,
  output logic dec_var,
  output logic dec_known
);
  // pure lookup; columns follow the low nibble addressing form
  always_comb begin
    dec_len = CTM_LEN_1;
    dec_cyc = CTM_CYC_1;
    dec_var = 1'b0;
    dec_known = 1'b1;
    if (op_code[3]) begin
      // bank register forms
      case (op_code[7:4])
        4'h7, 4'h8, 4'ha: begin
          dec_len = CTM_LEN_2;
          dec_cyc = CTM_CYC_2;
        end
        4'hb, 4'hd: dec_known = 1'b0;
        default: dec_cyc = CTM_CYC_1;
      endcase
    end else begin
      case (op_code[3:0])
        // indirect ram forms
        4'h6, 4'h7: begin
          dec_cyc = CTM_CYC_2;
          if (op_code[7:4] == 4'h7 || op_code[7:4] == 4'h8 ||
              op_code[7:4] == 4'ha) begin
            dec_len = CTM_LEN_2;
          end else if (op_code[7:4] == 4'hb) begin
            dec_known = 1'b0;
          end
        end
        // direct byte forms
        4'h5: begin
          case (op_code[7:4])
            4'h7, 4'h8: begin
              dec_len = CTM_LEN_3;
              dec_cyc = CTM_CYC_3;
            end
            4'ha: dec_cyc = CTM_CYC_1;
            4'hb, 4'hd: dec_known = 1'b0;
            default: begin
              dec_len = CTM_LEN_2;
              dec_cyc = CTM_CYC_2;
            end
          endcase
        end
        // accumulator and immediate forms
        4'h4: begin
          case (op_code[7:4])
            4'h0, 4'h1, 4'hc, 4'hd, 4'he: dec_cyc = CTM_CYC_1;
            4'h8: dec_cyc = CTM_CYC_8;
            4'ha: dec_cyc = CTM_CYC_4;
            4'hb: dec_known = 1'b0;
            4'hf: dec_cyc = CTM_CYC_2;
            default: begin
              dec_len = CTM_LEN_2;
              dec_cyc = CTM_CYC_2;
            end
          endcase
        end
        // rotates, immediate to direct, code and external reads
        4'h3: begin
          case (op_code[7:4])
            4'h0, 4'h1, 4'h2, 4'h3, 4'ha, 4'hc: dec_cyc = CTM_CYC_1;
            4'h4, 4'h5, 4'h6: begin
              dec_len = CTM_LEN_3;
              dec_cyc = CTM_CYC_3;
            end
            4'h8, 4'he, 4'hf: dec_cyc = CTM_CYC_3;
            4'h9: begin
              dec_cyc = CTM_VAR_MIN;
              dec_var = 1'b1;
            end
            default: dec_known = 1'b0;
          endcase
        end
        // accumulator into direct, clear bit, external by pointer
        4'h2: begin
          case (op_code[7:4])
            4'h4, 4'h5, 4'h6, 4'hc: begin
              dec_len = CTM_LEN_2;
              dec_cyc = CTM_CYC_2;
            end
            4'he, 4'hf: dec_cyc = CTM_CYC_3;
            default: dec_known = 1'b0;
          endcase
        end
        // stack, data pointer load, external by data pointer
        4'h0: begin
          case (op_code[7:4])
            4'h0: dec_cyc = CTM_CYC_1;
            4'h9: begin
              dec_len = CTM_LEN_3;
              dec_cyc = CTM_CYC_3;
            end
            4'hc, 4'hd: begin
              dec_len = CTM_LEN_2;
              dec_cyc = CTM_CYC_2;
            end
            4'he, 4'hf: dec_cyc = CTM_CYC_3;
            default: dec_known = 1'b0;
          endcase
        end
        // branch and call column is handled elsewhere
        default: dec_known = 1'b0;
      endcase
    end
  end
endmodule

/* ctm_timing_asserts.sv */
`timescale 1ns/10ps
// watches the timing block from its ports only
module ctm_timing_chk
  import ctm_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // offer
  input wire logic op_valid,
  input wire logic [7:0] op_code,
  input wire logic [7:0] op_arg,
  input wire logic [ctm_pkg::CTM_BANK_W-1:0] bank_sel,
  // sequencing and addressing
  input wire logic op_ready,
  input wire logic busy,
  input wire logic ins_done,
  input wire logic [1:0] ins_len,
  input wire logic [3:0] cyc_cnt,
  input wire logic [ctm_pkg::CTM_RADR_W-1:0] reg_addr,
  input wire logic [ctm_pkg::CTM_RADR_W-1:0] ptr_addr,
  input wire logic direct_sfr,
  input wire logic alu_wr
);
  // one domain, so clock and reset are given once
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  // an opcode is taken at this edge
  logic take;
  assign take = op_valid && op_ready;
  ////////////////////////////////////////////////////////////////////////////
  AST_TAKE_START: assert property (take |=> busy && cyc_cnt == 4'h1)
    else $error("busy or count not started after take");
  AST_COUNT_STEP: assert property (busy && !op_ready |=> busy && cyc_cnt == $past(cyc_cnt) + 4'h1)
    else $error("clock count did not step by one");
  AST_REG_ADDR: assert property (take |=> reg_addr == {$past(bank_sel), $past(op_code[2:0])})
    else $error("register address wrong");
  AST_PTR_ADDR: assert property (take |=> ptr_addr == {$past(bank_sel), 2'h0, $past(op_code[0])})
    else $error("pointer address wrong");
  AST_DIRECT_SPACE: assert property (take |=> direct_sfr == $past(op_arg[7]))
    else $error("direct space select wrong");
  AST_ONE_CLOCK: assert property (take && op_code == 8'h28 |=> op_ready && ins_len == 2'h1 && alu_wr)
    else $error("register add not one byte one clock");
  AST_MUL_FOUR: assert property (take && op_code == 8'ha4 |=> !op_ready [*3] ##1 op_ready)
    else $error("multiply not four clocks");
  AST_DIV_EIGHT: assert property (take && op_code == 8'h84 |=> !op_ready [*7] ##1 op_ready)
    else $error("divide not eight clocks");
  AST_CODE_READ: assert property (take && op_code == 8'h93 |=> !op_ready [*3] ##[1:4] op_ready)
    else $error("code read outside four to seven clocks");
  AST_DONE_IDLE: assert property ($fell(busy) |-> ins_done ##1 !ins_done)
    else $error("done pulse wrong at idle");
endmodule
// the checker rides along every instance of the timing block
bind ctm_timing ctm_timing_chk u_chk (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid),
  .op_code(op_code), .op_arg(op_arg), .bank_sel(bank_sel), .op_ready(op_ready), .busy(busy),
  .ins_done(ins_done), .ins_len(ins_len), .cyc_cnt(cyc_cnt), .reg_addr(reg_addr),
  .ptr_addr(ptr_addr), .direct_sfr(direct_sfr), .alu_wr(alu_wr));

/* ctm_timing_bench.sv */
`timescale 1ns/10ps
// compare one value pair and count it
`define CHK(got, exp, msg) \
  num_checks++; \
  if ((got) !== (exp)) begin \
    err_count++; \
    $display("unexpected %0t %s", $time, msg); \
  end
module ctm_timing_bench;
  import ctm_pkg::*;
  // clock and reset
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  // design inputs, all valued at time zero
  logic op_valid = 1'b0;
  logic [7:0] op_code = 8'h00;
  logic [7:0] op_arg = 8'h00;
  logic [ctm_pkg::CTM_BANK_W-1:0] bank_sel = '0;
  logic [7:0] acc_in = 8'h00;
  logic [7:0] opnd_in = 8'h00;
  logic cy_in = 1'b0;
  logic ac_in = 1'b0;
  logic ov_in = 1'b0;
  logic code_rdy = 1'b0;
  // design outputs
  logic op_ready, busy, ins_done, ins_known, alu_wr, alu_cy, alu_ac, alu_ov, direct_sfr;
  logic [1:0] ins_len;
  logic [3:0] ins_cyc, cyc_cnt;
  logic [ctm_pkg::CTM_RADR_W-1:0] reg_addr, ptr_addr;
  logic [7:0] alu_res;
  // bookkeeping
  int err_count = 0;
  int num_checks = 0;
  logic [31:0] seed = 32'h0000000f;
  ctm_timing u_dut (.clk_sys(clk_sys), .rst_n(rst_n), .op_valid(op_valid), .op_code(op_code),
    .op_arg(op_arg), .bank_sel(bank_sel), .acc_in(acc_in), .opnd_in(opnd_in), .cy_in(cy_in),
    .ac_in(ac_in), .ov_in(ov_in), .code_rdy(code_rdy), .op_ready(op_ready), .busy(busy),
    .ins_done(ins_done), .ins_len(ins_len), .ins_cyc(ins_cyc), .cyc_cnt(cyc_cnt),
    .ins_known(ins_known), .reg_addr(reg_addr), .ptr_addr(ptr_addr), .direct_sfr(direct_sfr),
    .alu_res(alu_res), .alu_wr(alu_wr), .alu_cy(alu_cy), .alu_ac(alu_ac), .alu_ov(alu_ov));
  ////////////////////////////////////////////////////////////////////////////
  // 100 MHz system clock
  initial begin
    forever #5 clk_sys = ~clk_sys;
  end
  // xorshift keeps the operand stream repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // print counts and verdict, then stop
  task automatic results();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // offer one opcode at a falling edge and follow it to its last clock;
  // returns on the falling edge whose clock may take the next opcode
  task automatic run(input logic [7:0] op, input int len, input int cyc);
    int k, a, b, c, r;
    logic [2:0] f;
    logic known;
    a = int'(rnd() & 255);
    b = int'(rnd() & 255);
    c = int'(rnd() & 1);
    op_code = op;
    op_arg = 8'(rnd());
    acc_in = a[7:0];
    opnd_in = b[7:0];
    cy_in = c[0];
    ac_in = 1'(rnd());
    ov_in = 1'(rnd());
    bank_sel = CTM_BANK_W'(rnd());
    code_rdy = 1'b0;
    op_valid = 1'b1;
    known = 1'b1;
    // flags of the arithmetic forms, worked out in integers
    if (op == 8'h28) c = 0;
    if (op == 8'h98) begin
      r = a - b - c;
      f = {a < b + c, (a & 15) < (b & 15) + c, ((a & 127) < (b & 127) + c) ^ (a < b + c)};
    end else begin
      r = a + b + c;
      f = {r > 255, (a & 15) + (b & 15) + c > 15, ((a & 127) + (b & 127) + c > 127) ^ (r > 255)};
    end
    // results of the single byte logic and rotate forms
    case (op)
      8'h58: r = a & b;
      8'h48: r = a | b;
      8'h68: r = a ^ b;
      8'he4: r = 0;
      8'hf4: r = ~a;
      8'h23: r = ((a << 1) | (a >> 7)) & 255;
      8'hc4: r = ((a << 4) | (a >> 4)) & 255;
      8'h28, 8'h38, 8'h98: known = 1'b1;
      default: known = 1'b0;
    endcase
    for (k = 1; k <= 9; k++) begin
      @(negedge clk_sys);
      if (k == 1) begin
        `CHK(ins_len, len[1:0], "byte length")
        `CHK(reg_addr, {bank_sel, op[2:0]}, "register address")
        `CHK(direct_sfr, op_arg[7], "direct space")
        `CHK(ins_known, op != 8'h80, "table membership")
        if (op != 8'h93) begin
          `CHK(ins_cyc, cyc[3:0], "clock figure")
        end
        if (known) begin
          `CHK({alu_wr, alu_res}, {1'b1, r[7:0]}, "result")
        end
        if (op inside {8'h28, 8'h38, 8'h98}) begin
          `CHK({alu_cy, alu_ac, alu_ov}, f, "flags")
        end
      end
      `CHK({busy, cyc_cnt}, {1'b1, k[3:0]}, "clock count")
      // the stretched code read finishes one clock after its ready
      if (op == 8'h93 && k == cyc - 1) code_rdy = 1'b1;
      if (op_ready === 1'b1) break;
    end
    `CHK(k, cyc, "duration")
    `CHK(ins_cyc, cyc[3:0], "clocks spent")
    if (k > 9) results();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // main sequence: every form back to back, then idle
  initial begin
    int i;
    repeat (2) @(negedge clk_sys);
    `CHK({op_ready, busy, ins_done, alu_wr}, 4'h0, "reset state")
    rst_n = 1'b1;
    for (i = 0; i < 4 && op_ready !== 1'b1; i++) @(negedge clk_sys);
    `CHK(op_ready, 1'b1, "ready after reset")
    run(8'h28, 1, 1);
    run(8'h38, 1, 1);
    run(8'h98, 1, 1);
    run(8'h58, 1, 1);
    run(8'h48, 1, 1);
    run(8'h68, 1, 1);
    run(8'he8, 1, 1);
    run(8'h27, 1, 2);
    run(8'h56, 1, 2);
    run(8'h25, 2, 2);
    run(8'h65, 2, 2);
    run(8'h74, 2, 2);
    run(8'h94, 2, 2);
    run(8'h53, 3, 3);
    run(8'h43, 3, 3);
    run(8'h62, 2, 2);
    run(8'h85, 3, 3);
    run(8'h90, 3, 3);
    for (i = 4; i <= 7; i++) run(8'h93, 1, i);
    run(8'h83, 1, 3);
    run(8'he2, 1, 3);
    run(8'hf0, 1, 3);
    run(8'hc0, 2, 2);
    run(8'hd0, 2, 2);
    run(8'hd7, 1, 2);
    run(8'hc5, 2, 2);
    run(8'hcb, 1, 1);
    run(8'h23, 1, 1);
    run(8'h13, 1, 1);
    run(8'hc4, 1, 1);
    run(8'he4, 1, 1);
    run(8'hf4, 1, 2);
    run(8'ha6, 2, 2);
    run(8'hf7, 1, 2);
    run(8'h86, 2, 2);
    run(8'ha3, 1, 1);
    run(8'hd4, 1, 1);
    run(8'ha4, 1, 4);
    run(8'h84, 1, 8);
    run(8'h80, 1, 1);
    $display("test back to back forms done");
    // no new offer: the pipeline drains and marks the end once
    op_valid = 1'b0;
    @(negedge clk_sys);
    `CHK({busy, ins_done, op_ready}, 3'b011, "end of run")
    @(negedge clk_sys);
    `CHK(ins_done, 1'b0, "done pulse length")
    $display("test drain done");
    results();
  end
endmodule
